// [bench/tbc_ctrl_tb_top.sv]
// Self-checking bench for the triple regulator command control block.
`timescale 1ns/1ps
`default_nettype none
module tbc_ctrl_tb_top import tbc_pkg::*;;
  typedef struct packed {
    logic [2:0] cmd;
    logic [3:0] adr;
    logic [7:0] dat;
    logic rd;
    logic [3:0] regs;
    logic [6:0] code;
    logic [7:0] rep;
  } tbc_row_t;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic enable = 1'b0;
  logic [3:0] address = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wreq;
  logic lclk, hd, hoe, dd, doe, core_on, sec_on, thr_on, cls;
  logic [6:0] code;
  logic [31:0] bv;
  wire logic wire_d;
  wire logic [3:0] regs_w;
  int error_cnt = 0;
  int n_compared = 0;
  // A released line shows the inverse of the host's last driven bit, never a kind guess.
  assign wire_d = doe ? dd : (hoe ? hd : ~hd);
  assign regs_w = {core_on, sec_on, thr_on, cls};
  tbc_ctrl DUT (.mclk_i(mclk), .rst_n_i(rst_n), .enable_i(enable), .link_clk_i(lclk),
    .link_data_line_i(wire_d), .link_data_line_o(dd), .link_data_line_oe_o(doe),
    .core_on_o(core_on), .second_regulator_on_o(sec_on), .third_regulator_on_o(thr_on),
    .core_code_o(code), .closed_loop_scaling_o(cls), .avs_address(address), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wreq));
  tbc_host_model host (.link_clk_o(lclk), .host_d_o(hd), .host_oe_o(hoe), .wire_i(wire_d));
  initial begin
    forever #10 mclk = ~mclk;
  end
  // ****************************************************************
  // Checking and bus tasks
  // ****************************************************************
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    address <= a;
    wdata <= wd;
    wr <= w;
    rd <= ~w;
    @(posedge mclk);
    while (wreq !== 1'b0 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    bv = rdata;
    if (wreq !== 1'b0) begin
      error_cnt++;
      final_report();
    end
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic run_row(input tbc_row_t r);
    logic [7:0] rep;
    host.send(r.cmd, r.adr, r.dat, r.rd, rep);
    @(negedge mclk);
    chk("regulators", {28'h0, r.regs}, {28'h0, regs_w});
    chk("core code", {25'h0, r.code}, {25'h0, code});
    if (r.rd) begin
      chk("reply", {24'h0, r.rep}, {24'h0, rep});
    end
  endtask : run_row
  task automatic send_cmd(input logic [2:0] c);
    logic [7:0] rep;
    host.send(c, 4'h0, 8'h00, 1'b0, rep);
  endtask : send_cmd
  // Regulator columns are core, second, third, then closed-loop mode.
  tbc_row_t rows [18] = '{
    '{CMD_VADJ, 4'h0, 8'h10, 1'b0, 4'he, 7'h10, 8'h00},
    '{CMD_VADJ, 4'h0, 8'hff, 1'b0, 4'he, 7'h7d, 8'h00},
    '{CMD_REG_WRITE, 4'h0, 8'h20, 1'b0, 4'he, 7'h20, 8'h00},
    '{CMD_REG_WRITE, 4'ha, 8'h01, 1'b0, 4'hc, 7'h20, 8'h00},
    '{CMD_REG_WRITE, 4'ha, 8'h02, 1'b0, 4'ha, 7'h20, 8'h00},
    '{CMD_REG_WRITE, 4'h1, 8'h03, 1'b0, 4'hb, 7'h20, 8'h00},
    '{CMD_VADJ, 4'h0, 8'h30, 1'b0, 4'hb, 7'h30, 8'h00},
    '{CMD_REG_READ, 4'h1, 8'h00, 1'b1, 4'hb, 7'h30, 8'h03},
    '{CMD_REG_READ, 4'h0, 8'h00, 1'b1, 4'hb, 7'h30, 8'h30},
    '{CMD_SLEEP, 4'h0, 8'h00, 1'b0, 4'h3, 7'h30, 8'h00},
    '{CMD_WAKEUP, 4'h0, 8'h00, 1'b0, 4'hb, 7'h30, 8'h00},
    '{CMD_AUTH, 4'h0, 8'h00, 1'b1, 4'hb, 7'h30, 8'hc3},
    '{CMD_REG_WRITE, 4'h1, 8'h02, 1'b0, 4'h1, 7'h30, 8'h00},
    '{CMD_RESET, 4'h0, 8'h00, 1'b0, 4'he, 7'h58, 8'h00},
    '{CMD_SHUTDOWN, 4'h0, 8'h00, 1'b0, 4'h0, 7'h58, 8'h00},
    '{CMD_RESET, 4'h0, 8'h00, 1'b0, 4'he, 7'h58, 8'h00},
    '{CMD_REG_READ, 4'ha, 8'h00, 1'b1, 4'he, 7'h58, 8'h03},
    '{CMD_REG_READ, 4'h5, 8'h00, 1'b1, 4'he, 7'h58, 8'h00}};
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    chk("reset code", {25'h0, CODE_RST}, {25'h0, code});
    chk("reset regulators", 32'h0, {28'h0, regs_w});
    @(posedge mclk);
    rst_n <= 1'b1;
    enable <= 1'b1;
    repeat (8) @(posedge mclk);
    bus(1'b0, BUS_STATUS, 32'h0);
    chk("status", 32'h1e, bv);
    bus(1'b1, BUS_CODE, 32'h11);
    bus(1'b0, BUS_CODE, 32'h0);
    chk("bus code", 32'h58, bv);
    bus(1'b1, BUS_AUTH_ID, 32'hc3);
    bus(1'b0, BUS_AUTH_ID, 32'h0);
    chk("auth id", 32'hc3, bv);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, bv);
    $display("test bus done");
    foreach (rows[i]) begin
      run_row(rows[i]);
    end
    $display("test commands done");
    send_cmd(CMD_SLEEP);
    @(posedge mclk);
    enable <= 1'b0;
    repeat (8) @(posedge mclk);
    chk("enable low", 32'h0, {28'h0, regs_w});
    send_cmd(CMD_WAKEUP);
    bus(1'b0, BUS_STATUS, 32'h0);
    chk("wakeup while low", 32'h40, bv);
    send_cmd(CMD_RESET);
    @(negedge mclk);
    chk("reset while low", 32'h0, {28'h0, regs_w});
    send_cmd(CMD_SLEEP);
    bus(1'b0, BUS_STATUS, 32'h0);
    chk("sleep while low", 32'h0, bv);
    @(posedge mclk);
    enable <= 1'b1;
    repeat (8) @(posedge mclk);
    chk("enable rise", 32'he, {28'h0, regs_w});
    $display("test enable done");
    bus(1'b1, BUS_AUTH_ID, 32'h77);
    @(posedge mclk);
    rst_n <= 1'b0;
    send_cmd(CMD_SHUTDOWN);
    @(negedge mclk);
    chk("mid reset", 32'h0, {28'h0, regs_w});
    @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    chk("after reset", 32'he, {28'h0, regs_w});
    bus(1'b0, BUS_AUTH_ID, 32'h0);
    chk("auth after reset", {24'h0, AUTH_ID_RST}, bv);
    $display("test reset done");
    final_report();
  end
endmodule : tbc_ctrl_tb_top
`default_nettype wire

// [bench/tbc_host_model.sv]
// Host side model that drives the serial power link of the regulator block.
`timescale 1ns/1ps
`default_nettype none
module tbc_host_model (
  // Link pins
  output logic link_clk_o,
  output logic host_d_o,
  output logic host_oe_o,
  input wire logic wire_i
);
  initial begin
    link_clk_o = 1'b0;
    host_d_o = 1'b0;
    host_oe_o = 1'b0;
  end
  // ****************************************************************
  // Frame transfer
  // ****************************************************************
  // The clock stands still between frames; its high phase is short so that
  // reply bits have settled long before the host samples them.
  task automatic send(input logic [2:0] cmd, input logic [3:0] adr, input logic [7:0] dat,
                      input logic rd, output logic [7:0] rep);
    logic [15:0] f;
    f = {1'b1, cmd, adr, dat};
    rep = 8'h00;
    #7;
    host_oe_o = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      #40 host_d_o = f[i];
      #80 link_clk_o = 1'b1;
      #40 link_clk_o = 1'b0;
    end
    host_oe_o = 1'b0;
    if (rd) begin
      for (int i = 7; i >= 0; i--) begin
        #120 rep[i] = wire_i;
        link_clk_o = 1'b1;
        #40 link_clk_o = 1'b0;
      end
    end
    #320;
  endtask : send
endmodule : tbc_host_model
`default_nettype wire

// [verilog/tbc_ctrl.sv]
// Command interpreter and regulator enable control for a triple regulator unit.
`timescale 1ns/1ps
`default_nettype none
module tbc_ctrl
  import tbc_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Enable pin and serial link
  input wire logic enable_i,
  input wire logic link_clk_i,
  input wire logic link_data_line_i,
  output logic link_data_line_o,
  output logic link_data_line_oe_o,
  // Regulator controls
  output logic core_on_o,
  output logic second_regulator_on_o,
  output logic third_regulator_on_o,
  output logic [6:0] core_code_o,
  output logic closed_loop_scaling_o,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [1:0] en_sy_ff, sck_sy_ff, dat_sy_ff;
  logic en_d_ff, sck_d_ff;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_sy_ff <= 2'h0;
      sck_sy_ff <= 2'h0;
      dat_sy_ff <= 2'h0;
      en_d_ff <= 1'b0;
      sck_d_ff <= 1'b0;
    end else begin
      en_sy_ff <= {en_sy_ff[0], enable_i};
      sck_sy_ff <= {sck_sy_ff[0], link_clk_i};
      dat_sy_ff <= {dat_sy_ff[0], link_data_line_i};
      en_d_ff <= en_sy_ff[1];
      sck_d_ff <= sck_sy_ff[1];
    end
  end
  wire en_s = en_sy_ff[1];
  wire en_rise = en_s & ~en_d_ff;
  wire sck_rise = sck_sy_ff[1] & ~sck_d_ff;
  wire sck_fall = ~sck_sy_ff[1] & sck_d_ff;

  // Limits a requested code to the core window.
  function automatic logic [6:0] clamp_code(input logic [7:0] req);
    clamp_code = (req > {1'b0, CODE_MAX}) ? CODE_MAX : req[6:0];
  endfunction : clamp_code

  // ****************************************************************
  // Frame receiver
  // ****************************************************************
  // A frame is a high start bit, then command, address and data, MSB first,
  // all sampled on link clock rising edges.
  logic [FRAME_BITS-1:0] rx_sr_ff;
  logic [3:0] rx_cnt_ff;
  logic exec_ff;
  logic tx_busy_ff;
  wire rx_start = sck_rise & ~tx_busy_ff & (rx_cnt_ff == 4'h0) & dat_sy_ff[1];
  wire rx_bit = sck_rise & (rx_cnt_ff != 4'h0);
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_sr_ff <= '0;
      rx_cnt_ff <= 4'h0;
      exec_ff <= 1'b0;
    end else begin
      exec_ff <= rx_bit & (rx_cnt_ff == 4'(FRAME_BITS));
      if (rx_start) begin
        rx_cnt_ff <= 4'h1;
      end else if (rx_bit) begin
        rx_sr_ff <= {rx_sr_ff[FRAME_BITS-2:0], dat_sy_ff[1]};
        rx_cnt_ff <= (rx_cnt_ff == 4'(FRAME_BITS)) ? 4'h0 : rx_cnt_ff + 4'h1;
      end
    end
  end

  // ****************************************************************
  // Command decode
  // ****************************************************************
  wire [2:0] cmd = rx_sr_ff[CMD_MSB:CMD_LSB];
  wire [3:0] adr = rx_sr_ff[ADR_MSB:ADR_LSB];
  wire [7:0] dat = rx_sr_ff[7:0];
  wire do_vadj = exec_ff & (cmd == CMD_VADJ);
  wire do_reset = exec_ff & (cmd == CMD_RESET);
  wire do_sleep = exec_ff & (cmd == CMD_SLEEP) & en_s;
  wire do_wake = exec_ff & (cmd == CMD_WAKEUP) & en_s;
  wire do_shut = exec_ff & (cmd == CMD_SHUTDOWN);
  wire do_rd = exec_ff & (cmd == CMD_REG_READ);
  wire do_wr = exec_ff & (cmd == CMD_REG_WRITE);
  wire do_auth = exec_ff & (cmd == CMD_AUTH);

  // ****************************************************************
  // Link registers and regulator state
  // ****************************************************************
  logic [6:0] code_ff;
  logic [1:0] mode_ff;
  logic [1:0] ctrl_ff;
  logic shut_ff, asleep_ff;
  logic [7:0] auth_id_ff;
  logic [2:0] last_cmd_ff;
  wire wr_code = do_vadj | (do_wr & (adr == LREG_CORE_VOLT));
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_ff <= CODE_RST;
      mode_ff <= MODE_RST;
      ctrl_ff <= CTRL_RST;
      shut_ff <= 1'b0;
      asleep_ff <= 1'b0;
      last_cmd_ff <= 3'h0;
    end else if (do_reset) begin
      code_ff <= CODE_RST;
      mode_ff <= MODE_RST;
      ctrl_ff <= CTRL_RST;
      shut_ff <= 1'b0;
      asleep_ff <= 1'b0;
      last_cmd_ff <= cmd;
    end else begin
      if (exec_ff) begin
        last_cmd_ff <= cmd;
      end
      if (wr_code) begin
        code_ff <= clamp_code(dat);
      end
      if (do_wr & (adr == LREG_MODE)) begin
        mode_ff <= dat[1:0];
      end
      if (do_wr & (adr == LREG_REG_CTRL)) begin
        ctrl_ff <= dat[1:0];
      end
      // A fresh enable clears any earlier shutdown or sleep.
      if (do_shut) begin
        shut_ff <= 1'b1;
      end else if (en_rise) begin
        shut_ff <= 1'b0;
      end
      if (do_sleep) begin
        asleep_ff <= 1'b1;
      end else if (do_wake | en_rise) begin
        asleep_ff <= 1'b0;
      end
    end
  end

  // Who starts a voltage change in each mode lies outside this block:
  // the code follows what the link writes, clamped to CODE_MAX.
  wire unit_on = en_s & ~shut_ff & mode_ff[MODE_ON_BIT];
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_on_o <= 1'b0;
      second_regulator_on_o <= 1'b0;
      third_regulator_on_o <= 1'b0;
      core_code_o <= CODE_RST;
      closed_loop_scaling_o <= 1'b0;
    end else begin
      core_on_o <= unit_on & ~asleep_ff;
      second_regulator_on_o <= unit_on & ctrl_ff[CTRL_REG2_BIT];
      third_regulator_on_o <= unit_on & ctrl_ff[CTRL_REG3_BIT];
      core_code_o <= code_ff;
      closed_loop_scaling_o <= mode_ff[MODE_LOOP_BIT];
    end
  end

  // ****************************************************************
  // Reply transmitter
  // ****************************************************************
  // Reply bits change on link clock falling edges so the host can sample
  // them on the rising edges that follow the frame.
  wire [7:0] rd_val = (adr == LREG_CORE_VOLT) ? {1'b0, code_ff} :
                      (adr == LREG_MODE) ? {6'h0, mode_ff} :
                      (adr == LREG_REG_CTRL) ? {6'h0, ctrl_ff} : 8'h00;
  logic [7:0] tx_sr_ff;
  logic [3:0] tx_cnt_ff;
  logic tx_out_ff;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_sr_ff <= 8'h00;
      tx_cnt_ff <= 4'h0;
      tx_out_ff <= 1'b0;
      tx_busy_ff <= 1'b0;
    end else if (do_rd | do_auth) begin
      tx_sr_ff <= do_rd ? rd_val : auth_id_ff;
      tx_cnt_ff <= 4'(REPLY_BITS);
      tx_busy_ff <= 1'b1;
    end else if (sck_fall & tx_busy_ff) begin
      if (tx_cnt_ff != 4'h0) begin
        tx_out_ff <= tx_sr_ff[7];
        tx_sr_ff <= {tx_sr_ff[6:0], 1'b0};
        tx_cnt_ff <= tx_cnt_ff - 4'h1;
      end else begin
        tx_busy_ff <= 1'b0;
        tx_out_ff <= 1'b0;
      end
    end
  end
  assign link_data_line_o = tx_out_ff;
  assign link_data_line_oe_o = tx_busy_ff;

  // ****************************************************************
  // Software bus slave
  // ****************************************************************
  // One wait state per access keeps read data registered.
  logic ack_ff;
  logic [31:0] rdata_ff;
  wire req = avs_read | avs_write;
  wire [31:0] bus_val = (avs_address == BUS_STATUS) ?
                          {24'h0, tx_busy_ff, asleep_ff, shut_ff, en_s, core_on_o,
                           second_regulator_on_o, third_regulator_on_o,
                           closed_loop_scaling_o} :
                        (avs_address == BUS_CODE) ? {25'h0, code_ff} :
                        (avs_address == BUS_AUTH_ID) ? {24'h0, auth_id_ff} :
                        (avs_address == BUS_LAST_CMD) ? {29'h0, last_cmd_ff} : 32'h0;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0;
      auth_id_ff <= AUTH_ID_RST;
    end else begin
      ack_ff <= req & ~ack_ff;
      if (avs_read & ~ack_ff) begin
        rdata_ff <= bus_val;
      end
      if (avs_write & ack_ff & (avs_address == BUS_AUTH_ID)) begin
        auth_id_ff <= avs_writedata[7:0];
      end
    end
  end
  assign avs_waitrequest = req & ~ack_ff;
  assign avs_readdata = rdata_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_en_low_off;
    @(posedge mclk_i) disable iff (!rst_n_i)
      !en_s |=> !core_on_o && !second_regulator_on_o && !third_regulator_on_o;
  endproperty
  a_en_low_off: assert property (p_en_low_off) else $error("regulator on with enable low");

  property p_en_rise_on;
    @(posedge mclk_i) disable iff (!rst_n_i)
      en_rise && mode_ff[MODE_ON_BIT] && !exec_ff ##1 en_s && !exec_ff |=> core_on_o;
  endproperty
  a_en_rise_on: assert property (p_en_rise_on) else $error("core not on after enable");

  property p_code_range;
    @(posedge mclk_i) disable iff (!rst_n_i)
      core_code_o <= CODE_MAX;
  endproperty
  a_code_range: assert property (p_code_range) else $error("core code out of range");

  property p_shutdown;
    @(posedge mclk_i) disable iff (!rst_n_i)
      do_shut && !en_rise |=> ##1 !core_on_o && !second_regulator_on_o && !third_regulator_on_o;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown left a regulator on");

  property p_reset_cmd;
    @(posedge mclk_i) disable iff (!rst_n_i)
      do_reset |=> code_ff == CODE_RST && ctrl_ff == CTRL_RST && mode_ff == MODE_RST
        && !shut_ff && !asleep_ff;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset command left state");

  property p_sleep;
    @(posedge mclk_i) disable iff (!rst_n_i)
      do_sleep ##1 en_s |=> !core_on_o && second_regulator_on_o == $past(second_regulator_on_o, 2);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep handled wrongly");

  property p_sleep_ignored;
    @(posedge mclk_i) disable iff (!rst_n_i)
      exec_ff && (cmd == CMD_SLEEP || cmd == CMD_WAKEUP) && !en_s && !en_rise |=> $stable(asleep_ff);
  endproperty
  a_sleep_ignored: assert property (p_sleep_ignored) else $error("sleep taken with enable low");

  property p_vadj;
    @(posedge mclk_i) disable iff (!rst_n_i)
      do_vadj |=> code_ff == clamp_code($past(rx_sr_ff[7:0]));
  endproperty
  a_vadj: assert property (p_vadj) else $error("voltage adjust not applied");

  property p_regctrl;
    @(posedge mclk_i) disable iff (!rst_n_i)
      do_wr && adr == LREG_REG_CTRL && unit_on && !en_rise |=> ##1
        third_regulator_on_o == $past(rx_sr_ff[CTRL_REG3_BIT], 2);
  endproperty
  a_regctrl: assert property (p_regctrl) else $error("regulator bit not applied");

  property p_second_ctrl;
    @(posedge mclk_i) disable iff (!rst_n_i)
      do_wr && adr == LREG_REG_CTRL ##1 unit_on |=>
        second_regulator_on_o == $past(rx_sr_ff[CTRL_REG2_BIT], 2);
  endproperty
  a_second_ctrl: assert property (p_second_ctrl) else $error("second bit not applied");

  property p_mode_loop;
    @(posedge mclk_i) disable iff (!rst_n_i)
      do_wr && adr == LREG_MODE |=> ##1 closed_loop_scaling_o == $past(rx_sr_ff[MODE_LOOP_BIT], 2);
  endproperty
  a_mode_loop: assert property (p_mode_loop) else $error("scaling mode not applied");

  property p_wake;
    @(posedge mclk_i) disable iff (!rst_n_i)
      do_wake ##1 unit_on |=> core_on_o;
  endproperty
  a_wake: assert property (p_wake) else $error("core not on after wakeup");

  property p_reply_start;
    @(posedge mclk_i) disable iff (!rst_n_i)
      do_rd || do_auth |=> link_data_line_oe_o;
  endproperty
  a_reply_start: assert property (p_reply_start) else $error("reply not started");

  property p_reply_end;
    @(posedge mclk_i) disable iff (!rst_n_i)
      tx_busy_ff && sck_fall && tx_cnt_ff == 4'h0 && !exec_ff |=> !link_data_line_oe_o;
  endproperty
  a_reply_end: assert property (p_reply_end) else $error("reply drive not released");
endmodule : tbc_ctrl
`default_nettype wire

// [verilog/tbc_pkg.sv]
// Shared constants for the triple regulator command control block.
package tbc_pkg;
  // ****************************************************************
  // Link frame layout
  // ****************************************************************
  localparam int FRAME_BITS = 15;
  localparam int CMD_MSB = 14;
  localparam int CMD_LSB = 12;
  localparam int ADR_MSB = 11;
  localparam int ADR_LSB = 8;
  localparam int REPLY_BITS = 8;
  // ****************************************************************
  // Link commands
  // ****************************************************************
  localparam logic [2:0] CMD_VADJ = 3'h0;
  localparam logic [2:0] CMD_RESET = 3'h1;
  localparam logic [2:0] CMD_SLEEP = 3'h2;
  localparam logic [2:0] CMD_SHUTDOWN = 3'h3;
  localparam logic [2:0] CMD_WAKEUP = 3'h4;
  localparam logic [2:0] CMD_REG_READ = 3'h5;
  localparam logic [2:0] CMD_REG_WRITE = 3'h6;
  localparam logic [2:0] CMD_AUTH = 3'h7;
  // ****************************************************************
  // Link register map and reset values
  // ****************************************************************
  localparam logic [3:0] LREG_CORE_VOLT = 4'h0;
  localparam logic [3:0] LREG_MODE = 4'h1;
  localparam logic [3:0] LREG_REG_CTRL = 4'ha;
  localparam int MODE_ON_BIT = 0;
  localparam int MODE_LOOP_BIT = 1;
  localparam int CTRL_REG2_BIT = 0;
  localparam int CTRL_REG3_BIT = 1;
  localparam logic [6:0] CODE_RST = 7'h58;
  localparam logic [6:0] CODE_MAX = 7'h7d;
  localparam logic [1:0] MODE_RST = 2'h1;
  localparam logic [1:0] CTRL_RST = 2'h3;
  // ****************************************************************
  // Software bus map
  // ****************************************************************
  localparam logic [3:0] BUS_STATUS = 4'h0;
  localparam logic [3:0] BUS_CODE = 4'h4;
  localparam logic [3:0] BUS_AUTH_ID = 4'h8;
  localparam logic [3:0] BUS_LAST_CMD = 4'hc;
  // Arbitrary value returned by the authenticate command until changed.
  localparam logic [7:0] AUTH_ID_RST = 8'h5a;
endpackage : tbc_pkg
